// *** serial_peer.sv ***
// Far-side serial peer: returns a byte and makes the clock in slave mode.
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
   // Clock and wires
   input wire logic clock,
   input wire logic sck,
   input wire logic serial_out_pin,
   output logic serial_in_pin,
   output logic sck_drv,
   // Control
   input wire logic lsb,
   input wire logic go,
   input wire logic [7:0] tx,
   output logic [7:0] rx
);
   int n = 0;
   logic sck_last = 1'b1;
   initial
   begin
      serial_in_pin = 1'b0;
      sck_drv = 1'b1;
      rx = 8'h00;
   end
   // Only moves between known levels count, so the unknown pin before reset makes no edge.
   // After the last bit the line is turned over so a stale level cannot pass.
   always @(sck)
   begin
      if (sck_last === 1'b1 && sck === 1'b0)
         serial_in_pin = lsb ? tx[n] : tx[7 - n];
      else if (sck_last === 1'b0 && sck === 1'b1)
      begin
         rx[lsb ? n : 7 - n] = serial_out_pin;
         n = (n + 1) % 8;
         if (n == 0)
            serial_in_pin <= #25 ~serial_in_pin;
      end
      sck_last = sck;
   end
   always @(posedge go)
      repeat (16)
      begin
         repeat (6) @(posedge clock);
         sck_drv <= ~sck_drv;
      end
endmodule
`default_nettype wire

// *** sync_serial_io_port.sv ***
// Three-wire synchronous serial port with APB register access.
//
// Chosen here: the APB interface to the registers.
`include "sync_serial_io_port_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sync_serial_io_port (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Fixed mask options
   input wire logic lsb_first_option,
   input wire logic clock_rate_select_lo,
   input wire logic clock_rate_select_hi,
   // General-purpose port B drive for bits 5..7
   input wire logic [2:0] gpio_out,
   input wire logic [2:0] gpio_oe,
   // Port B pins 5..7
   input wire logic [2:0] pb_pin_in,
   output logic [2:0] pb_pin_out,
   output logic [2:0] pb_pin_oe
);

   // The fastest rate keeps three clocks per half period. A bit that the far side
   // changes on a falling edge needs two clocks through the input synchroniser,
   // and a shorter half period would sample the previous bit on the rising edge.
   function automatic logic [4:0] half_period(input logic [1:0] sel);
      case (sel)
         2'b00: half_period = `HALF_SEL0;
         2'b01: half_period = `HALF_SEL1;
         2'b10: half_period = `HALF_SEL2;
         default: half_period = `HALF_SEL3;
      endcase
   endfunction

   sync_serial_io_port_pkg::xfer_state_e state_r;
   sync_serial_io_port_pkg::xfer_state_e state_nxt;
   logic enable_r;
   logic master_r;
   logic done_r;
   logic col_r;
   logic armed_r;
   logic fell_r;
   logic sck_r;
   logic sdo_r;
   logic [2:0] cnt_r;
   logic [4:0] tmr_r;
   logic [7:0] data_r;
   logic [31:0] prdata_r;
   logic sck_s1;
   logic sck_s2;
   logic sck_s3;
   logic sdi_s1;
   logic sdi_s2;

   // Register decode.
   wire setup_w = psel & ~penable;
   wire access_w = psel & penable;
   wire hit_ctrl = paddr == {`IDX_CTRL, 2'b00};
   wire hit_flags = paddr == {`IDX_FLAGS, 2'b00};
   wire hit_data = paddr == {`IDX_DATA, 2'b00};
   wire mapped_w = hit_ctrl | hit_flags | hit_data;
   wire ctrl_wr = access_w & pwrite & hit_ctrl;
   wire flags_rd = access_w & ~pwrite & hit_flags;
   wire data_wr = access_w & pwrite & hit_data;
   wire data_acc = access_w & hit_data;
   wire [7:0] ctrl_view = 8'h00 | ({7'h00, enable_r} << `BIT_ENABLE) | ({7'h00, master_r} << `BIT_MASTER);
   wire [7:0] flags_view = 8'h00 | ({7'h00, done_r} << `BIT_DONE) | ({7'h00, col_r} << `BIT_COL);
   wire [7:0] rd_mux = hit_ctrl ? ctrl_view : hit_flags ? flags_view : hit_data ? data_r : 8'h00;

   assign prdata = prdata_r;
   assign pready = 1'b1;
   assign pslverr = access_w & ~mapped_w;

   // Shift engine controls.
   wire shifting = state_r == sync_serial_io_port_pkg::ST_SHIFT;
   wire new_master = pwdata[`BIT_MASTER];
   wire abort_w = ~enable_r | (ctrl_wr & (new_master != master_r)) | (ctrl_wr & ~pwdata[`BIT_ENABLE]);
   wire [4:0] half_w = half_period({clock_rate_select_hi, clock_rate_select_lo});
   wire tick_w = master_r & shifting & (tmr_r == half_w - 5'h01);
   wire m_fall = tick_w & sck_r;
   wire m_rise = tick_w & ~sck_r;
   wire s_fall = ~master_r & sck_s3 & ~sck_s2;
   wire s_rise = ~master_r & ~sck_s3 & sck_s2;
   wire fall_ev = master_r ? m_fall : s_fall;
   wire rise_ev = (master_r ? m_rise : s_rise) & shifting;
   wire last_rise = rise_ev & (cnt_r == `LAST_BIT);
   wire start_w = enable_r & ~abort_w & ~shifting & (master_r ? data_wr : s_fall);
   wire done_set = last_rise & ~abort_w;
   wire col_set = data_acc & shifting & fell_r;
   wire clr_w = armed_r & data_acc;
   wire [7:0] shift_in = lsb_first_option ? {sdi_s2, data_r[7:1]} : {data_r[6:0], sdi_s2};
   wire out_bit = lsb_first_option ? data_r[0] : data_r[7];

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         sync_serial_io_port_pkg::ST_IDLE:
         begin
            if (start_w)
               state_nxt = sync_serial_io_port_pkg::ST_SHIFT;
         end
         sync_serial_io_port_pkg::ST_SHIFT:
         begin
            if (abort_w || last_rise)
               state_nxt = sync_serial_io_port_pkg::ST_IDLE;
         end
         default: state_nxt = sync_serial_io_port_pkg::ST_IDLE;
      endcase
   end

   // Pin takeover; bit 5 is the shift output, bit 6 input, bit 7 the clock.
   assign pb_pin_out[0] = enable_r ? sdo_r : gpio_out[0];
   assign pb_pin_oe[0] = enable_r | gpio_oe[0];
   assign pb_pin_out[1] = gpio_out[1];
   assign pb_pin_oe[1] = ~enable_r & gpio_oe[1];
   assign pb_pin_out[2] = (enable_r & master_r) ? sck_r : gpio_out[2];
   assign pb_pin_oe[2] = enable_r ? master_r : gpio_oe[2];

   // Pin synchronisers; the first stage feeds only the second.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         sck_s1 <= 1'b1;
         sck_s2 <= 1'b1;
         sck_s3 <= 1'b1;
         sdi_s1 <= 1'b0;
         sdi_s2 <= 1'b0;
      end
      else
      begin
         sck_s1 <= pb_pin_in[2];
         sck_s2 <= sck_s1;
         sck_s3 <= sck_s2;
         sdi_s1 <= pb_pin_in[1];
         sdi_s2 <= sdi_s1;
      end
   end

   // Control bits; only the two defined bits are stored.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         {enable_r, master_r} <= `CTRL_RESET;
         prdata_r <= 32'h00000000;
      end
      else
      begin
         if (ctrl_wr)
         begin
            enable_r <= pwdata[`BIT_ENABLE];
            master_r <= new_master;
         end
         if (setup_w)
            prdata_r <= {24'h000000, rd_mux};
      end
   end

   // Flags: a setting event wins over a clear in the same cycle.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         done_r <= 1'b0;
         col_r <= 1'b0;
         armed_r <= 1'b0;
      end
      else
      begin
         done_r <= done_set | (done_r & ~clr_w);
         col_r <= col_set | (col_r & ~clr_w);
         if (flags_rd)
            armed_r <= prdata_r[`BIT_DONE];
         else if (data_acc)
            armed_r <= 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_r <= sync_serial_io_port_pkg::ST_IDLE;
         cnt_r <= 3'h0;
         tmr_r <= 5'h00;
         sck_r <= 1'b1;
         fell_r <= 1'b0;
         sdo_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         if (abort_w || !shifting)
            cnt_r <= 3'h0;
         else if (rise_ev)
            cnt_r <= cnt_r + 3'h1;
         tmr_r <= (tick_w || !shifting) ? 5'h00 : tmr_r + 5'h01;
         if (abort_w || !shifting)
            sck_r <= 1'b1;
         else if (tick_w)
            sck_r <= ~sck_r;
         if (start_w & ~master_r)
            fell_r <= 1'b1;
         else if (fall_ev & shifting)
            fell_r <= 1'b1;
         else if (!shifting || abort_w)
            fell_r <= 1'b0;
         if ((fall_ev & shifting) | (start_w & ~master_r))
            sdo_r <= out_bit;
      end
   end

   // Shared shift and data register; no reset so software content survives it.
   always_ff @(posedge clock)
   begin
      if (data_wr)
         data_r <= pwdata[7:0];
      else if (rise_ev & ~abort_w)
         data_r <= shift_in;
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_idle_clock_high: assert property (enable_r && master_r && !shifting |-> pb_pin_out[2])
      else $error("Shift clock not high while idle.");
   a_done_on_last: assert property (last_rise && !abort_w |=> done_r && !shifting)
      else $error("Done flag missing after last rising edge.");
   a_abort_disable: assert property (!enable_r |=> !shifting && cnt_r == 3'h0)
      else $error("Transfer not aborted while disabled.");
   a_col_on_access: assert property (data_acc && shifting && fell_r |=> col_r)
      else $error("Collision flag not set by busy access.");
   a_master_start: assert property (data_wr && enable_r && master_r && !shifting && !ctrl_wr |=> shifting)
      else $error("Master write did not start a transfer.");
   a_pin_takeover: assert property (enable_r |-> pb_pin_oe[0] && !pb_pin_oe[1] && pb_pin_out[0] == sdo_r)
      else $error("Port pins not taken over when enabled.");
   a_flag_clear: assert property (clr_w && !done_set |=> !done_r)
      else $error("Done flag not cleared by sequence.");
   a_master_abort: assert property (ctrl_wr && master_r && !new_master |=> !shifting)
      else $error("Clearing master did not abort.");
   a_clock_dir: assert property (enable_r && !master_r |-> !pb_pin_oe[2])
      else $error("Slave mode drives the shift clock.");
   a_falls_then_rise: assert property (m_fall && !abort_w |-> ##[1:16] (m_rise || abort_w))
      else $error("Master clock did not rise after falling.");

   // Checks on flag clearing and holding, pin release, shifting only while enabled, the output bit, data writes and the read data.
   a_col_clear: assert property (clr_w && !col_set |=> !col_r)
      else $error("Collision flag not cleared by sequence.");
   a_done_sticky: assert property (done_r && !clr_w |=> done_r)
      else $error("Done flag dropped without clear sequence.");
   a_gpio_release: assert property (!enable_r |-> pb_pin_oe == gpio_oe && pb_pin_out == gpio_out)
      else $error("Port pins not returned to general use.");
   a_busy_enabled: assert property (shifting |-> enable_r)
      else $error("Transfer running while disabled.");
   a_bit_on_fall: assert property (fall_ev && shifting |=> sdo_r == $past(out_bit))
      else $error("Output bit not presented on falling edge.");
   a_data_overwrite: assert property (data_wr |=> data_r == $past(pwdata[7:0]))
      else $error("Data write did not overwrite the register.");
   a_read_upper_zero: assert property (prdata[31:8] == 24'h000000)
      else $error("Unused read data bits not zero.");

   c_master_done: cover property (master_r && last_rise);
   c_slave_done: cover property (!master_r && last_rise);
   c_collision: cover property (col_set);
   c_clear_seq: cover property (clr_w && done_r);

endmodule
`default_nettype wire

// *** sync_serial_io_port_bench.sv ***
// Self-checking bench for the serial port.
`timescale 1ns/1ps
`default_nettype none
module sync_serial_io_port_bench;
   localparam logic [11:0] ctl_a = 12'h028;
   localparam logic [11:0] flg_a = 12'h02c;
   localparam logic [11:0] dat_a = 12'h030;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic lsb = 1'b0;
   logic [1:0] rate = 2'h0;
   logic [2:0] pin_out;
   logic [2:0] pin_oe;
   logic serial_in_pin;
   logic sck_drv;
   logic go = 1'b0;
   logic [7:0] tx = 8'h00;
   logic [7:0] rx;
   logic err;
   logic [31:0] q;
   wire logic sck_w = pin_oe[2] ? pin_out[2] : sck_drv;
   wire logic sdo_w = pin_oe[0] ? pin_out[0] : 1'b1;
   int fails = 0;
   int samples_checked = 0;
   sync_serial_io_port i_sync_serial_io_port (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .lsb_first_option(lsb), .clock_rate_select_lo(rate[0]), .clock_rate_select_hi(rate[1]),
      .gpio_out(3'h5), .gpio_oe(3'h7), .pb_pin_in({sck_w, serial_in_pin, sdo_w}), .pb_pin_out(pin_out),
      .pb_pin_oe(pin_oe));
   serial_peer i_serial_peer (.clock(clock), .sck(sck_w), .serial_out_pin(sdo_w), .serial_in_pin(serial_in_pin), .sck_drv(sck_drv),
      .lsb(lsb), .go(go), .tx(tx), .rx(rx));
   initial
   begin
      forever #5 clock = ~clock;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_done();
      int k = 0;
      q = 32'h0;
      while (q[7] !== 1'b1 && k < 200)
      begin
         apb(1'b0, flg_a, 32'h0);
         k++;
      end
      check({31'h0, q[7]}, 32'h1);
   endtask
   task automatic one_byte(input logic [7:0] d, input logic [7:0] t);
      tx <= t;
      apb(1'b1, dat_a, {24'h0, d});
      wait_done();
      check({24'h0, rx}, {24'h0, d});
      apb(1'b0, dat_a, 32'h0);
      check(q, {24'h0, t});
      apb(1'b0, flg_a, 32'h0);
      check(q, 32'h0);
   endtask
   task automatic test_reset();
      apb(1'b0, ctl_a, 32'h0);
      check(q, 32'h0);
      apb(1'b0, flg_a, 32'h0);
      check(q, 32'h0);
      apb(1'b1, 12'h034, 32'hff);
      check({31'h0, err}, 32'h1);
      $display("reset test over");
   endtask
   task automatic test_master();
      apb(1'b1, ctl_a, 32'h50);
      @(posedge clock);
      check({29'h0, pin_oe}, 32'h5);
      check({31'h0, pin_out[2]}, 32'h1);
      for (int i = 0; i < 4; i++)
      begin
         lsb <= i[0];
         rate <= 2'(i);
         one_byte(8'ha5 ^ 8'(i), 8'h3c + 8'(i));
      end
      $display("master test over");
   endtask
   task automatic test_collision();
      tx <= 8'h0f;
      apb(1'b1, dat_a, 32'h69);
      repeat (40) @(posedge clock);
      apb(1'b0, dat_a, 32'h0);
      wait_done();
      check(q, 32'hc0);
      apb(1'b0, dat_a, 32'h0);
      apb(1'b0, flg_a, 32'h0);
      check(q, 32'h0);
      $display("collision test over");
   endtask
   task automatic test_slave();
      apb(1'b1, ctl_a, 32'h40);
      @(posedge clock);
      check({29'h0, pin_oe}, 32'h1);
      tx <= 8'h96;
      apb(1'b1, dat_a, 32'h81);
      go <= 1'b1;
      wait_done();
      go <= 1'b0;
      check({24'h0, rx}, 32'h81);
      apb(1'b0, dat_a, 32'h0);
      check(q, 32'h96);
      $display("slave test over");
   endtask
   task automatic test_abort();
      apb(1'b1, ctl_a, 32'h50);
      apb(1'b1, dat_a, 32'h33);
      repeat (40) @(posedge clock);
      apb(1'b1, ctl_a, 32'h0);
      @(posedge clock);
      check({26'h0, pin_oe, pin_out}, 32'h3d);
      repeat (300) @(posedge clock);
      apb(1'b0, flg_a, 32'h0);
      check(q, 32'h0);
      $display("abort test over");
   endtask
   task automatic test_reset_keeps_data();
      apb(1'b1, dat_a, 32'h5a);
      rst <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      apb(1'b0, dat_a, 32'h0);
      check(q, 32'h5a);
      apb(1'b0, ctl_a, 32'h0);
      check(q, 32'h0);
      apb(1'b0, flg_a, 32'h0);
      check(q, 32'h0);
      $display("mid-run reset test over");
   endtask
   task automatic tally_and_finish();
      $display("fails %0d samples_checked %0d", fails, samples_checked);
      if (fails == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      test_reset();
      test_master();
      test_collision();
      test_slave();
      test_abort();
      test_reset_keeps_data();
      tally_and_finish();
   end
   initial
   begin
      #300us;
      fails++;
      tally_and_finish();
   end
endmodule
`default_nettype wire

// *** sync_serial_io_port_defines.svh ***
// Offsets, field positions, reset values and timing counts of the serial port.
`ifndef SYNC_SERIAL_IO_PORT_DEFINES_SVH
`define SYNC_SERIAL_IO_PORT_DEFINES_SVH
`define IDX_CTRL 10'h00a
`define IDX_FLAGS 10'h00b
`define IDX_DATA 10'h00c
`define BIT_ENABLE 6
`define BIT_MASTER 4
`define BIT_DONE 7
`define BIT_COL 6
`define CTRL_RESET 2'b00
`define HALF_SEL0 5'h03
`define HALF_SEL1 5'h04
`define HALF_SEL2 5'h08
`define HALF_SEL3 5'h10
`define LAST_BIT 3'h7
`endif

// *** sync_serial_io_port_pkg.sv ***
// Types shared by the serial port design.
`default_nettype none
package sync_serial_io_port_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SHIFT = 2'b10
   } xfer_state_e;
endpackage
`default_nettype wire
